// ### design/vector_map_pkg.sv
package vector_map_pkg;

    // Vector numbering and table layout.
    localparam int        NUM_MASKABLE   = 48;
    localparam logic [7:0] FIRST_MASKABLE = 8'h10;
    localparam logic [7:0] VEC_RESET      = 8'h00;
    localparam logic [7:0] VEC_FETCH_PROT = 8'h06;
    localparam logic [7:0] VEC_DATA_PROT  = 8'h07;
    localparam logic [7:0] VEC_DATA_ERR   = 8'h08;
    localparam logic [7:0] VEC_UNDEF_OP   = 8'h0E;
    localparam logic [7:0] VEC_NMI        = 8'h0F;
    localparam logic [7:0] VEC_OS_FIRST   = 8'h40;
    localparam logic [7:0] VEC_SWI_FIRST  = 8'h42;
    localparam logic [9:0] OFFSET_TOP     = 10'h3FC;

    // Levels: a smaller value is more urgent, the all-ones value is off.
    localparam logic [4:0] LEVEL_EXC      = 5'h00;
    localparam logic [4:0] LEVEL_NMI      = 5'h0F;
    localparam logic [4:0] LEVEL_OFF      = 5'h1F;

    // Maskable vectors (index = vector - 16) that own a resource number.
    localparam logic [47:0] RN_PRESENT    = 48'h1E00_1FC3_FFFF;

    // Pulse generator channels on the shared timer vectors 40 to 44.
    localparam logic [47:0] PG_MASK_V40   = 48'h0300_C030_0C03;
    localparam logic [47:0] PG_MASK_V41   = 48'h0803_00C0_300C;
    localparam logic [47:0] PG_MASK_V42   = 48'h0000_0000_0000;
    localparam logic [47:0] PG_MASK_V43   = 48'h100C_0300_C030;
    localparam logic [47:0] PG_MASK_V44   = 48'h00C0_300C_0300;
    // Only pulse generator channels 0 to 23 may request a transfer.
    localparam logic [47:0] PG_DMA_OK     = 48'h0000_00FF_FFFF;

    typedef logic [4:0]                       level_t;
    typedef logic [NUM_MASKABLE-1:0][4:0]     level_table_t;

    // Core exception requests, held until entry is taken.
    typedef struct packed {
        logic fetch_prot;
        logic data_prot;
        logic data_err;
        logic undef_op;
    } exc_req_s;

    // Peripheral request lines in the processor clock domain.
    typedef struct packed {
        logic [7:0]  reload_tmr;
        logic [6:0]  uart_rx;
        logic [6:0]  uart_status;
        logic [6:0]  uart_tx;
        logic [2:0]  frt_event;
        logic [47:0] pulse_gen;
        logic [2:0]  ram_diag;
        logic [2:0]  bram_diag;
        logic [1:0]  ocu_match;
        logic [47:0] misc;
    } periph_req_s;

    // One exception entry handed to the core.
    typedef struct packed {
        logic [7:0]  vector;
        logic [31:0] address;
        level_t      level;
    } entry_s;

    typedef enum logic [1:0] {
        ST_RESET_FETCH,
        ST_IDLE,
        ST_WAIT_ACK
    } entry_state_e;

    // Table address of a vector: base plus 0x3FC minus four times vector.
    function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                             input logic [7:0]  vec);
        logic [9:0] off;
        off = OFFSET_TOP - {vec, 2'b00};
        return base + {22'h00_0000, off};
    endfunction : vec_addr

endpackage : vector_map_pkg

// ### design/level_sync.sv
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 17
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             reset_i,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second, to let metastability settle.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule : level_sync

// ### design/level_arbiter.sv
`timescale 1ns/1ps
module level_arbiter #(
    parameter int N = 48
) (
    // Pending maskable vectors and their level settings.
    input  wire logic [N-1:0]                    pending_i,
    input  wire logic [N-1:0][4:0]               level_i,
    // Winner: most urgent level, lowest vector on a tie.
    output logic                                 win_valid_o,
    output logic [5:0]                           win_idx_o,
    output vector_map_pkg::level_t               win_level_o
);

    // Scanning downward with <= lets the lower vector win a tie.
    always_comb begin
        win_valid_o = 1'b0;
        win_idx_o   = 6'h00;
        win_level_o = vector_map_pkg::LEVEL_OFF;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending_i[i] && level_i[i] != vector_map_pkg::LEVEL_OFF &&
                level_i[i] <= win_level_o) begin
                win_valid_o = 1'b1;
                win_idx_o   = 6'(i);
                win_level_o = level_i[i];
            end
        end
    end

endmodule : level_arbiter

// ### design/interrupt_vector_mapper.sv
// Notes on behaviour
// - Fetch protection violation: vector 6, offset 0x3E4.
// - Data protection violation: vector 7, offset 0x3E0.
// - Data access error: vector 8, offset 0x3DC, no transfer.
// - Undefined opcode: vector 14, offset 0x3C4.
// - Four non-maskable sources share vector 15 at level 15.
// - External lines 8-15 and low-voltage event share vector 17.
// - Low-voltage event never requests a transfer.
// - Serial ch.0 receive/status use vector 20, transmit vector 21.
// - Serial status events never request a transfer.
// - Vectors without resource number never request a transfer.
// - Reload timers 4-7 interrupt only; 0-3 may request transfers.
// - Pulse generator channels 24-47 never request a transfer.
// - Free-run timer 0 events: vector 40, resource 24.
// - RAM events: vector 35; backup RAM events: vector 36.
// - Compare channels 8 and 9: vector 59, resource 43.
// - Vectors 64 and 65 have no hardware source.
// - Vectors 66 to 255 come only from the software instruction.
`timescale 1ns/1ps
module interrupt_vector_mapper #(
    parameter int NUM_VEC = vector_map_pkg::NUM_MASKABLE
) (
    // Clock and reset.
    input  wire logic                          mclk_i,
    input  wire logic                          reset_i,
    // Table base and per-vector level settings from the core.
    input  wire logic [31:0]                   vector_table_base_i,
    input  wire vector_map_pkg::level_table_t  vector_level_register_i,
    input  wire vector_map_pkg::level_t        cpu_level_mask_i,
    // Core exception requests and software interrupt instruction.
    input  wire vector_map_pkg::exc_req_s      exc_i,
    input  wire logic                          swi_req_i,
    input  wire logic [7:0]                    swi_vector_i,
    // Non-maskable sources: bus diag, crossbar_ram, backup RAM, unit.
    input  wire logic [3:0]                    nmi_src_i,
    // Pins: external interrupt lines and low-voltage detector.
    input  wire logic [15:0]                   ext_int_i,
    input  wire logic                          lvd_i,
    // Peripheral request lines in the processor clock domain.
    input  wire vector_map_pkg::periph_req_s   periph_i,
    // Exception entry handshake with the core.
    input  wire logic                          entry_ack_i,
    output logic                               entry_valid_o,
    output vector_map_pkg::entry_s             entry_o,
    output logic                               swi_reject_o,
    // Transfer requests, one per dma_resource_number.
    output logic [NUM_VEC-1:0]                 dma_req_o
);

    // Synchronised pins.
    logic [15:0]                 ext_int_s;
    logic                        lvd_s;

    // Per-vector request and transfer terms, index = vector - 16.
    logic [NUM_VEC-1:0]          spec_irq;
    logic [NUM_VEC-1:0]          spec_dma;
    logic [NUM_VEC-1:0]          vec_irq;
    logic [NUM_VEC-1:0]          vec_dma;

    // Arbiter result for the maskable vectors.
    logic                        win_valid;
    logic [5:0]                  win_idx;
    vector_map_pkg::level_t      win_level;

    // Entry selection.
    logic                        sel_valid;
    logic [7:0]                  sel_vec;
    vector_map_pkg::level_t      sel_level;
    logic                        swi_ok;

    // State and output registers.
    vector_map_pkg::entry_state_e state_reg;
    vector_map_pkg::entry_state_e state_next;
    logic                        entry_valid_reg;
    vector_map_pkg::entry_s      entry_reg;
    logic                        swi_reject_reg;
    logic [NUM_VEC-1:0]          dma_req_reg;

    // The external lines and the detector come straight off pins.
    level_sync #(
        .WIDTH (17)
    ) u_pin_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .async_i ({lvd_i, ext_int_i}),
        .sync_o  ({lvd_s, ext_int_s})
    );

    // Specific sources per vector; the rest stay low here
    // and may arrive on the misc lines.
    always_comb begin
        spec_irq = '0;
        spec_dma = '0;
        // Vector 16: external lines 0 to 7.
        spec_irq[0] = |ext_int_s[7:0];
        spec_dma[0] = |ext_int_s[7:0];
        // Vector 17: lines 8 to 15 plus the detector.
        spec_irq[1] = |ext_int_s[15:8] | lvd_s;
        spec_dma[1] = |ext_int_s[15:8];
        // Vectors 18 and 19: reload timers, upper four interrupt only.
        spec_irq[2] = periph_i.reload_tmr[0] | periph_i.reload_tmr[1] |
                      periph_i.reload_tmr[4] | periph_i.reload_tmr[5];
        spec_dma[2] = periph_i.reload_tmr[0] | periph_i.reload_tmr[1];
        spec_irq[3] = periph_i.reload_tmr[2] | periph_i.reload_tmr[3] |
                      periph_i.reload_tmr[6] | periph_i.reload_tmr[7];
        spec_dma[3] = periph_i.reload_tmr[2] | periph_i.reload_tmr[3];
        // The two lines above drop timers 4 to 7.
        // Vectors 20 to 33: serial channels 0 to 6, a pair each.
        for (int c = 0; c < 7; c++) begin
            spec_irq[4 + 2*c] = periph_i.uart_rx[c] |
                                periph_i.uart_status[c];
            spec_dma[4 + 2*c] = periph_i.uart_rx[c];
            spec_irq[5 + 2*c] = periph_i.uart_tx[c];
            spec_dma[5 + 2*c] = periph_i.uart_tx[c];
        end
        // Vectors 35 and 36: main and backup RAM diagnosis events.
        spec_irq[19] = |periph_i.ram_diag;
        spec_irq[20] = |periph_i.bram_diag;
        // Vectors 40 to 44: free-run timers 0 to 2 on 40 to 42, pulse generators on 40, 41, 43 and 44.
        spec_irq[24] = periph_i.frt_event[0] |
                       |(periph_i.pulse_gen &
                         vector_map_pkg::PG_MASK_V40);
        spec_dma[24] = periph_i.frt_event[0] |
                       |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V40 &
                         vector_map_pkg::PG_DMA_OK);
        spec_irq[25] = periph_i.frt_event[1] |
                       |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V41);
        spec_dma[25] = periph_i.frt_event[1] |
                       |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V41 &
                         vector_map_pkg::PG_DMA_OK);
        spec_irq[26] = periph_i.frt_event[2] |
                       |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V42);
        spec_dma[26] = periph_i.frt_event[2];
        spec_irq[27] = |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V43);
        spec_dma[27] = |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V43 &
                         vector_map_pkg::PG_DMA_OK);
        spec_irq[28] = |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V44);
        spec_dma[28] = |(periph_i.pulse_gen & vector_map_pkg::PG_MASK_V44 &
                         vector_map_pkg::PG_DMA_OK);
        // Vector 59: output_compare_channel 8 and 9 match.
        spec_irq[43] = |periph_i.ocu_match;
        spec_dma[43] = |periph_i.ocu_match;
    end

    // Each maskable vector merges its generic line; a transfer request
    // is only ever formed where the vector owns a resource number.
    generate
        for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
            assign vec_irq[v] = spec_irq[v] | periph_i.misc[v];
            assign vec_dma[v] = vector_map_pkg::RN_PRESENT[v] &
                                (spec_dma[v] | periph_i.misc[v]);
        end
    endgenerate

    // All sources sharing a vector compete under that one level.
    level_arbiter #(
        .N (NUM_VEC)
    ) u_arb (
        .pending_i   (vec_irq),
        .level_i     (vector_level_register_i),
        .win_valid_o (win_valid),
        .win_idx_o   (win_idx),
        .win_level_o (win_level)
    );

    // Only vectors 66 and up may be raised by the instruction; the two
    // reserved vectors below have no source.
    assign swi_ok = swi_req_i &&
                    swi_vector_i >= vector_map_pkg::VEC_SWI_FIRST;

    // Entry priority: core exceptions by number, then the non-maskable
    // vector, then the instruction, then the most urgent maskable one.
    always_comb begin
        sel_valid = 1'b1;
        sel_vec   = vector_map_pkg::VEC_RESET;
        sel_level = vector_map_pkg::LEVEL_EXC;
        if (exc_i.fetch_prot) begin
            sel_vec = vector_map_pkg::VEC_FETCH_PROT;
        end else if (exc_i.data_prot) begin
            sel_vec = vector_map_pkg::VEC_DATA_PROT;
        end else if (exc_i.data_err) begin
            sel_vec = vector_map_pkg::VEC_DATA_ERR;
        end else if (exc_i.undef_op) begin
            sel_vec = vector_map_pkg::VEC_UNDEF_OP;
        end else if (|nmi_src_i) begin
            sel_vec   = vector_map_pkg::VEC_NMI;
            sel_level = vector_map_pkg::LEVEL_NMI;
        end else if (swi_ok) begin
            sel_vec = swi_vector_i;
        end else if (win_valid && win_level < cpu_level_mask_i) begin
            sel_vec   = vector_map_pkg::FIRST_MASKABLE + {2'b00, win_idx};
            sel_level = win_level;
        end else begin
            sel_valid = 1'b0;
        end
    end

    // Entry state: the reset vector is offered first, then one entry at
    // a time is held until the core acknowledges it.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            vector_map_pkg::ST_RESET_FETCH: begin
                if (entry_ack_i) begin
                    state_next = vector_map_pkg::ST_IDLE;
                end
            end
            vector_map_pkg::ST_IDLE: begin
                if (sel_valid) begin
                    state_next = vector_map_pkg::ST_WAIT_ACK;
                end
            end
            vector_map_pkg::ST_WAIT_ACK: begin
                if (entry_ack_i) begin
                    state_next = vector_map_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = vector_map_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg <= vector_map_pkg::ST_RESET_FETCH;
        end else begin
            state_reg <= state_next;
        end
    end

    // Entry registers.  The choice is frozen while waiting, so a more
    // urgent late request waits for the next entry; this keeps
    // the address stable for the whole fetch.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            entry_valid_reg   <= 1'b1;
            entry_reg.vector  <= vector_map_pkg::VEC_RESET;
            entry_reg.address <= 32'h0000_0000;
            entry_reg.level   <= vector_map_pkg::LEVEL_EXC;
        end else if (state_reg == vector_map_pkg::ST_RESET_FETCH) begin
            entry_valid_reg   <= ~entry_ack_i;
            entry_reg.address <= vector_map_pkg::vec_addr(
                                     vector_table_base_i,
                                     vector_map_pkg::VEC_RESET);
        end else if (state_reg == vector_map_pkg::ST_IDLE) begin
            entry_valid_reg <= sel_valid;
            if (sel_valid) begin
                entry_reg.vector  <= sel_vec;
                entry_reg.address <= vector_map_pkg::vec_addr(
                                         vector_table_base_i,
                                         sel_vec);
                entry_reg.level   <= sel_level;
            end
        end else if (entry_ack_i) begin
            entry_valid_reg <= 1'b0;
        end
    end

    // An instruction request for a vector below 66 is refused and
    // flagged one cycle later, for as long as it stands; the core decides what follows.
    // It leaves no state behind.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            swi_reject_reg <= 1'b0;
        end else begin
            swi_reject_reg <= swi_req_i && !swi_ok;
        end
    end

    // Transfer requests follow their sources as levels, one cycle late (three for the pin lines, behind the sync flops),
    // whether or not the core has taken the vector.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            dma_req_reg <= '0;
        end else begin
            dma_req_reg <= vec_dma;
        end
    end

    assign entry_valid_o = entry_valid_reg;
    assign entry_o       = entry_reg;
    assign swi_reject_o  = swi_reject_reg;
    assign dma_req_o     = dma_req_reg;

endmodule : interrupt_vector_mapper

// ### test/interrupt_vector_mapper_assertions.sv
`timescale 1ns/1ps
module interrupt_vector_mapper_assertions #(
    parameter int NUM_VEC = 48
) (
    // Clock and reset.
    input wire logic                         mclk_i,
    input wire logic                         reset_i,
    // Watched inputs.
    input wire logic [31:0]                  vector_table_base_i,
    input wire logic                         swi_req_i,
    input wire logic [7:0]                   swi_vector_i,
    input wire logic [15:0]                  ext_int_i,
    input wire vector_map_pkg::periph_req_s  periph_i,
    input wire logic                         entry_ack_i,
    // Watched outputs.
    input wire logic                         entry_valid_o,
    input wire vector_map_pkg::entry_s       entry_o,
    input wire logic                         swi_reject_o,
    input wire logic [NUM_VEC-1:0]           dma_req_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    // Skip the edge that loads the reset address.
    chk_entry_stands: assert property (entry_valid_o && !entry_ack_i &&
        !$past(reset_i) |=> entry_valid_o && $stable(entry_o))
        else $error("entry changed before ack");
    chk_entry_addr: assert property (
        entry_valid_o && !$past(reset_i) |-> entry_o.address ==
        vector_table_base_i +
        {22'h00_0000, 10'h3FC - {entry_o.vector, 2'b00}})
        else $error("entry address wrong");
    chk_nmi_level: assert property (entry_valid_o &&
        entry_o.vector == 8'h0F |-> entry_o.level == 5'h0F)
        else $error("nmi level wrong");
    chk_os_unused: assert property (entry_valid_o |->
        entry_o.vector != 8'h40 && entry_o.vector != 8'h41)
        else $error("reserved vector entered");
    chk_swi_reject: assert property (swi_reject_o |->
        $past(swi_req_i && swi_vector_i < 8'h42))
        else $error("stray reject pulse");
    chk_lvd_no_dma: assert property (dma_req_o[1] &&
        !$past(periph_i.misc[1]) |-> $past(ext_int_i[15:8], 3) != 8'h00)
        else $error("lvd gave a transfer");
    chk_status_no_dma: assert property (dma_req_o[4] |->
        $past(periph_i.uart_rx[0] || periph_i.misc[4]))
        else $error("status gave a transfer");
    chk_rld_no_dma: assert property (dma_req_o[2] |->
        $past(periph_i.misc[2] || (|periph_i.reload_tmr[1:0])))
        else $error("transfer from reload timer 4 to 7");
    chk_pg_no_dma: assert property (dma_req_o[24] |->
        $past(periph_i.misc[24] || periph_i.frt_event[0] ||
        (|(periph_i.pulse_gen & 48'h0030_0C03))))
        else $error("transfer from pulse generator 24 to 47");
    chk_no_rn_dma: assert property (
        (dma_req_o & ~vector_map_pkg::RN_PRESENT) == '0)
        else $error("transfer without resource");
    chk_tx_dma: assert property (
        periph_i.uart_tx[0] |=> dma_req_o[5])
        else $error("transmit event gave no transfer");

    // Main scenarios.
    cov_nmi: cover property (entry_valid_o && entry_o.vector == 8'h0F);
    cov_reject: cover property (swi_reject_o);
    cov_dma_timer: cover property (dma_req_o[24]);
endmodule : interrupt_vector_mapper_assertions

// ### test/core_entry_model.sv
`timescale 1ns/1ps
module core_entry_model (
    // Clock, reset and pace.
    input  wire logic                    mclk_i,
    input  wire logic                    reset_i,
    input  wire logic                    slow_i,
    // Entry handshake.
    input  wire logic                    entry_valid_i,
    input  wire vector_map_pkg::entry_s  entry_i,
    output logic                         entry_ack_o,
    output vector_map_pkg::entry_s       got_o,
    output int                           taken_o
);
    logic [2:0] wait_reg;

    // Age of the standing entry; a slow core lets it stand four cycles longer.
    always_ff @(posedge mclk_i) begin
        if (reset_i || !entry_valid_i || entry_ack_o) wait_reg <= 3'h0;
        else wait_reg <= wait_reg + 3'h1;
    end

    // One ack per standing entry.
    always_ff @(posedge mclk_i) begin
        entry_ack_o <= !reset_i && entry_valid_i && !entry_ack_o &&
                       (wait_reg >= (slow_i ? 3'h4 : 3'h0));
    end

    // The entry is taken at the ack edge.
    always_ff @(posedge mclk_i) begin
        if (reset_i) taken_o <= 0;
        else if (entry_valid_i && entry_ack_o) begin
            got_o   <= entry_i;
            taken_o <= taken_o + 1;
        end
    end
endmodule : core_entry_model

// ### test/interrupt_vector_mapper_tb_top.sv
`timescale 1ns/1ps
module interrupt_vector_mapper_tb_top;
    logic mclk_i, reset_i, slow, swi_req, lvd, ack, valid, rej;
    logic [31:0] base;
    logic [7:0] swi_vec;
    logic [3:0] nmi;
    logic [15:0] ext;
    logic [47:0] dma;
    vector_map_pkg::level_table_t lvl;
    vector_map_pkg::level_t mask;
    vector_map_pkg::exc_req_s exc;
    vector_map_pkg::periph_req_s periph;
    vector_map_pkg::entry_s entry, got;
    int taken, err_total, num_checks;

    interrupt_vector_mapper interrupt_vector_mapper_i (
        .mclk_i(mclk_i), .reset_i(reset_i), .vector_table_base_i(base),
        .vector_level_register_i(lvl), .cpu_level_mask_i(mask),
        .exc_i(exc), .swi_req_i(swi_req), .swi_vector_i(swi_vec),
        .nmi_src_i(nmi), .ext_int_i(ext), .lvd_i(lvd), .periph_i(periph),
        .entry_ack_i(ack), .entry_valid_o(valid), .entry_o(entry),
        .swi_reject_o(rej), .dma_req_o(dma));
    core_entry_model core_entry_model_i (
        .mclk_i(mclk_i), .reset_i(reset_i), .slow_i(slow),
        .entry_valid_i(valid), .entry_i(entry), .entry_ack_o(ack),
        .got_o(got), .taken_o(taken));

    // Free-running 10 MHz clock.
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [47:0] exp,
                         input logic [47:0] seen);
        num_checks++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
            err_total++;
        end
    endtask : check

    // Waits for one accepted entry and judges it.
    task automatic expect_entry(input logic [7:0] v);
        int start;
        int n;
        start = taken;
        n = 0;
        while (taken == start && n < 40) begin
            @(negedge mclk_i);
            n++;
        end
        check("entry seen", 48'h1, n < 40);
        check("entry vector", v, got.vector);
        check("entry address", 32'h000F_FFFC - {22'h0, v, 2'b00}, got.address);
    endtask : expect_entry

    task automatic dma_case(input vector_map_pkg::periph_req_s p,
                            input int rn, input logic [7:0] v);
        periph = p;
        @(negedge mclk_i);
        check("dma", rn < 0 ? 48'h0 : 48'h1 << rn, dma);
        expect_entry(v);
        periph = '0;
        @(negedge mclk_i);
    endtask : dma_case

    task automatic scen_exceptions();
        logic [7:0] vecs [4];
        vecs = '{8'h06, 8'h07, 8'h08, 8'h0E};
        slow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            exc = 4'b1000 >> i;
            expect_entry(vecs[i]);
            check("exc level", 48'h0, got.level);
            check("exc dma", 48'h0, dma);
            exc = '0;
        end
        for (int i = 0; i < 4; i++) begin
            nmi = 4'h1 << i;
            expect_entry(8'h0F);
            check("nmi level", 48'hF, got.level);
            nmi = 4'h0;
        end
        slow = 1'b0;
    endtask : scen_exceptions

    // Two legal software vectors, two reserved ones refused.
    task automatic scen_swi();
        int start;
        swi_req = 1'b1;
        swi_vec = 8'h42;
        expect_entry(8'h42);
        swi_vec = 8'hFF;
        @(negedge mclk_i);
        expect_entry(8'hFF);
        swi_req = 1'b0;
        for (int i = 0; i < 2; i++) begin
            start = taken;
            swi_vec = 8'h40 + i;
            swi_req = 1'b1;
            @(negedge mclk_i);
            check("reject", 48'h1, rej);
            swi_req = 1'b0;
            repeat (6) @(negedge mclk_i);
            check("no entry", start, taken);
        end
    endtask : scen_swi

    // Equal levels pick the lower vector, else the more urgent level.
    task automatic scen_levels();
        lvl[4] = 5'h03;
        lvl[5] = 5'h03;
        periph.uart_rx[0] = 1'b1;
        periph.uart_tx[0] = 1'b1;
        @(negedge mclk_i);
        check("dma rx tx", 48'h30, dma);
        expect_entry(8'h14);
        periph.uart_rx[0] = 1'b0;
        expect_entry(8'h15);
        periph = '0;
        lvl[0] = 5'h07;
        lvl[47] = 5'h02;
        periph.misc[0] = 1'b1;
        periph.misc[47] = 1'b1;
        expect_entry(8'h3F);
        periph.misc[47] = 1'b0;
        expect_entry(8'h10);
        lvl[0] = 5'h10;
        repeat (4) @(negedge mclk_i);
        check("masked", 48'h0, valid);
        periph = '0;
    endtask : scen_levels

    task automatic scen_dma();
        vector_map_pkg::periph_req_s p;
        for (int i = 0; i < 48; i++) lvl[i] = 5'h04;
        p = '0; p.uart_status[0] = 1'b1;
        dma_case(p, -1, 8'h14);
        p = '0; p.reload_tmr[0] = 1'b1;
        dma_case(p, 2, 8'h12);
        p = '0; p.reload_tmr[4] = 1'b1;
        dma_case(p, -1, 8'h12);
        p = '0; p.reload_tmr[2] = 1'b1;
        dma_case(p, 3, 8'h13);
        p = '0; p.frt_event[0] = 1'b1;
        dma_case(p, 24, 8'h28);
        p = '0; p.pulse_gen[30] = 1'b1;
        dma_case(p, -1, 8'h28);
        p = '0; p.bram_diag[1] = 1'b1;
        dma_case(p, -1, 8'h24);
        p = '0; p.ocu_match = 2'b11;
        dma_case(p, 43, 8'h3B);
        p = '0; p.misc[18] = 1'b1;
        dma_case(p, -1, 8'h22);
    endtask : scen_dma

    // Pins pass two sync flops; leftover re-entries drain in the waits.
    task automatic scen_pins();
        lvd = 1'b1;
        repeat (3) @(negedge mclk_i);
        check("dma lvd", 48'h0, dma);
        expect_entry(8'h11);
        lvd = 1'b0;
        repeat (8) @(negedge mclk_i);
        ext[8] = 1'b1;
        repeat (3) @(negedge mclk_i);
        check("dma ext", 48'h2, dma);
        expect_entry(8'h11);
        ext = '0;
        repeat (8) @(negedge mclk_i);
    endtask : scen_pins

    task automatic give_verdict();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        {slow, swi_req, lvd, swi_vec, nmi, ext} = '0;
        {err_total, num_checks} = '0;
        base = 32'h000F_FC00;
        lvl = '1;
        mask = 5'h10;
        exc = '0;
        periph = '0;
        reset_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        reset_i = 1'b0;
        expect_entry(8'h00);
        scen_exceptions();
        scen_swi();
        scen_levels();
        scen_dma();
        scen_pins();
        give_verdict();
    end

    // Watchdog; the run needs under 800 cycles.
    initial begin
        #300_000;
        err_total++;
        give_verdict();
    end
endmodule : interrupt_vector_mapper_tb_top

bind interrupt_vector_mapper interrupt_vector_mapper_assertions #(
    .NUM_VEC(NUM_VEC)) chk_i (
    .mclk_i(mclk_i), .reset_i(reset_i),
    .vector_table_base_i(vector_table_base_i), .swi_req_i(swi_req_i),
    .swi_vector_i(swi_vector_i), .ext_int_i(ext_int_i),
    .periph_i(periph_i), .entry_ack_i(entry_ack_i),
    .entry_valid_o(entry_valid_o), .entry_o(entry_o),
    .swi_reject_o(swi_reject_o), .dma_req_o(dma_req_o));
